//--- rtl/pcs_socket_ctrl.sv
// Purpose: Socket control, status change masking and card strobe timing
// Assumes: Card pins are asynchronous and pass a three-stage synchroniser
// Notes:   Strobe outputs are retimed on the falling edge for half cycles
//
// Operation
// - Card reset output stays active while the reset control bit holds one.
// - Writing the software detect bit with detect enable set raises status change.
// - Leaving card power-down sets the software card detect source.
// - I/O width bit selects 8-bit or 16-bit I/O card registers.
// - With explicit acknowledge set, pending bits clear only on written ones.
// - With explicit acknowledge clear, reading the status change register clears it.
// - Power-down bit one removes socket power; zero keeps it powered.
// - Power-down is left only together with the software card detect write.
// - Mask bit seven gates ring indicate and status changed interrupts.
// - Request field 00 disables card interrupts; 01 interrupts while request low.
// - Request field 10 interrupts on a falling edge of the request pin.
// - Request field 11 interrupts on a rising edge of the request pin.
// - Ring indicate enable gates ring change, ignored for memory cards.
// - Ready enable gates ready change, ignored for I/O cards.
// - I/O card without ring enable: battery dead enable gates status low source.
// - Wait field codes give 5,6,7,9,11,12,14,28 clock strobe widths.
// - Assertion field codes give 0.5, 1.5, 3.5, 5.5 clock delays.
// - Negation field codes give 0, 1, 3, 5 clock delays.
// - Assertion delay leads the strobe; negation delay extends its release.
// - I/O timing register shares layout and resets to 100 10 01.
`default_nettype none

module pcs_socket_ctrl (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire pcs_pkg::pcs_axi_req_t s_axi_req,
    output var  pcs_pkg::pcs_axi_rsp_t s_axi_rsp,
    input  wire logic              card_irq_req_n,
    input  wire logic              status_changed_n,
    input  wire logic              card_ready,
    input  wire logic              card_detect_n,
    output logic                   card_reset,
    output logic                   socket_power_en,
    output logic                   io_access_16,
    output logic                   card_is_io,
    output logic                   status_change_irq,
    output logic                   access_busy,
    output logic                   card_output_enable_n,
    output logic                   card_write_enable_n
);
    import pcs_pkg::*;

    // ==================================================================
    // State
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_LEAD,
        ACC_STROBE
    } pcs_acc_state_t;

    typedef struct packed {
        logic [7:0]        glob;
        logic [7:0]        mask;
        logic [7:0]        memt;
        logic [7:0]        iot;
        logic [7:0]        chg;
        logic [3:0]        sync1;
        logic [3:0]        sync2;
        logic [3:0]        sync3;
        logic [3:0]        stable;

        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;

        pcs_axi_rsp_t      rsp;

        pcs_acc_state_t    acc;
        logic [5:0]        cnt;
        logic              acc_wr;
        logic              strobe;
        logic              irq;
        logic              acc_io;
        logic              busy;
        logic              pwr;
    } pcs_state_t;

    pcs_state_t s_reg;
    pcs_state_t s_next;

    logic [3:0] pins;
    logic [3:0] agree;
    logic [3:0] rise;
    logic [3:0] fall;

    logic [7:0] set_bits;
    logic [7:0] clr_bits;

    logic       do_write;
    logic       do_read;

    logic       wr_hit;
    logic       rd_hit;

    logic [7:0] wbyte;
    logic [7:0] rbyte;

    logic [7:0] tim;
    logic       swcd_wr;
    logic       pd_exit;

    logic       io;
    logic [1:0] irq_mode;
    logic       start;

    assign pins = {card_detect_n, card_ready, status_changed_n, card_irq_req_n};

    // ==================================================================
    // Next state
    always_comb begin
        s_next   = s_reg;
        set_bits = 8'h00;
        clr_bits = 8'h00;
        wr_hit   = 1'b0;
        rd_hit   = 1'b0;
        rbyte    = 8'h00;
        swcd_wr  = 1'b0;
        pd_exit  = 1'b0;
        start    = 1'b0;

        // Pin synchronisers
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        agree        = ~(s_reg.sync2 ^ s_reg.sync3);
        rise         = agree & s_reg.sync2 & ~s_reg.stable;
        fall         = agree & ~s_reg.sync2 & s_reg.stable;
        s_next.stable = (s_reg.stable & ~agree) | (s_reg.sync2 & agree);

        io       = s_reg.glob[GLB_TYPE];
        irq_mode = s_reg.mask[MSK_IRQ_H:MSK_IRQ_L];

        // Write channel capture
        if (s_axi_req.awvalid && s_reg.rsp.awready) begin
            s_next.awaddr      = s_axi_req.awaddr;
            s_next.rsp.awready = 1'b0;
        end
        if (s_axi_req.wvalid && s_reg.rsp.wready) begin
            s_next.wdata      = s_axi_req.wdata;
            s_next.wstrb      = s_axi_req.wstrb;
            s_next.rsp.wready = 1'b0;
        end
        if (s_reg.rsp.bvalid && s_axi_req.bready) begin
            s_next.rsp.bvalid = 1'b0;
        end

        // Write perform once address and data are both held
        do_write = !s_reg.rsp.awready && !s_reg.rsp.wready && !s_reg.rsp.bvalid;
        wbyte    = s_reg.wdata[7:0];
        if (do_write) begin
            s_next.rsp.awready = 1'b1;
            s_next.rsp.wready  = 1'b1;
            s_next.rsp.bvalid  = 1'b1;
            case (s_reg.awaddr)
                OFS_GLOBAL, OFS_MASK, OFS_MEMT, OFS_IOT, OFS_CHG, OFS_ACC: begin
                    wr_hit = 1'b1;
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            s_next.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLV;
            if (wr_hit && s_reg.wstrb[0]) begin
                case (s_reg.awaddr)
                    OFS_GLOBAL: begin
                        swcd_wr = wbyte[GLB_SWCD];
                        s_next.glob = {2'h0, wbyte[5], 1'b0, wbyte[3:0]};
                        if (s_reg.glob[GLB_PDOWN] && !wbyte[GLB_PDOWN]) begin
                            pd_exit = swcd_wr;
                            s_next.glob[GLB_PDOWN] = !swcd_wr;
                        end
                    end
                    OFS_MASK: begin
                        s_next.mask = wbyte;
                    end
                    OFS_MEMT: begin
                        s_next.memt = {1'b0, wbyte[6:0]};
                    end
                    OFS_IOT: begin
                        s_next.iot = {1'b0, wbyte[6:0]};
                    end
                    OFS_CHG: begin
                        if (s_reg.glob[GLB_EXPL]) begin
                            clr_bits = wbyte;
                        end
                    end
                    OFS_ACC: begin
                        start = wbyte[ACC_START] && !s_reg.glob[GLB_PDOWN]
                                && s_reg.acc == ACC_IDLE;
                        if (start) begin
                            s_next.acc_wr = wbyte[ACC_WRITE];
                            s_next.acc_io = wbyte[ACC_IO];
                        end
                    end
                    default: begin
                        start = 1'b0;
                    end
                endcase
            end
        end

        // Read channel
        do_read = s_axi_req.arvalid && s_reg.rsp.arready;
        if (s_reg.rsp.rvalid && s_axi_req.rready) begin
            s_next.rsp.rvalid  = 1'b0;
            s_next.rsp.arready = 1'b1;
        end
        if (do_read) begin
            rd_hit = 1'b1;
            case (s_axi_req.araddr)
                OFS_GLOBAL: begin
                    rbyte = s_reg.glob;
                end
                OFS_MASK: begin
                    rbyte = s_reg.mask;
                end
                OFS_MEMT: begin
                    rbyte = s_reg.memt;
                end
                OFS_IOT: begin
                    rbyte = s_reg.iot;
                end
                OFS_CHG: begin
                    rbyte = s_reg.chg;
                    if (!s_reg.glob[GLB_EXPL]) begin
                        clr_bits = s_reg.chg;
                    end
                end
                OFS_ACC: begin
                    rbyte = {7'h00, s_reg.acc != ACC_IDLE};
                end
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
            s_next.rsp.rvalid  = 1'b1;
            s_next.rsp.arready = 1'b0;
            s_next.rsp.rdata   = {24'h000000, rbyte};
            s_next.rsp.rresp   = rd_hit ? RESP_OKAY : RESP_SLV;
        end

        // Status change sources
        set_bits[CHG_SWCD] = (swcd_wr && s_reg.mask[MSK_CD]) || pd_exit;
        set_bits[CHG_CD]   = s_reg.mask[MSK_CD] && (rise[PIN_CD] || fall[PIN_CD]);
        case (irq_mode)
            IRQ_LEVEL: begin
                set_bits[CHG_IRQ] = !s_reg.stable[PIN_IRQ];
            end
            IRQ_FALL: begin
                set_bits[CHG_IRQ] = fall[PIN_IRQ];
            end
            IRQ_RISE: begin
                set_bits[CHG_IRQ] = rise[PIN_IRQ];
            end
            default: begin
                set_bits[CHG_IRQ] = 1'b0;
            end
        endcase
        set_bits[CHG_STS] = io && !s_reg.mask[MSK_RI] && s_reg.mask[MSK_BD]
                            && s_reg.mask[MSK_RISC] && !s_reg.stable[PIN_STS];
        set_bits[CHG_RI]  = io && s_reg.mask[MSK_RI] && s_reg.mask[MSK_RISC]
                            && fall[PIN_STS];
        set_bits[CHG_RDY] = !io && s_reg.mask[MSK_RDY]
                            && (rise[PIN_RDY] || fall[PIN_RDY]);

        // Set wins over clear
        s_next.chg = (s_reg.chg & ~clr_bits) | set_bits;
        s_next.irq = |s_next.chg;

        // Strobe sequencer
        tim = (wbyte[ACC_IO] && start) ? s_reg.iot : s_reg.memt;
        case (s_reg.acc)
            ACC_IDLE: begin
                s_next.strobe = 1'b0;
                if (start) begin
                    s_next.acc = ACC_LEAD;
                    s_next.cnt = DLY_FULL[tim[TIM_AS_H:TIM_AS_L]];
                    s_next.memt[7] = 1'b0;
                    s_next.iot[7]  = 1'b0;
                end
            end

            ACC_LEAD: begin
                if (s_reg.cnt == 6'h00) begin
                    s_next.acc    = ACC_STROBE;
                    s_next.strobe = 1'b1;
                    s_next.cnt    = 6'(s_reg.acc_io ?
                        (WAIT_CLK[s_reg.iot[TIM_WT_H:TIM_WT_L]]
                         + DLY_FULL[s_reg.iot[TIM_NG_H:TIM_NG_L]] - 6'h01) :
                        (WAIT_CLK[s_reg.memt[TIM_WT_H:TIM_WT_L]]
                         + DLY_FULL[s_reg.memt[TIM_NG_H:TIM_NG_L]] - 6'h01));
                end else begin
                    s_next.cnt = s_reg.cnt - 6'h01;
                end
            end

            ACC_STROBE: begin
                if (s_reg.cnt == 6'h00) begin
                    s_next.acc    = ACC_IDLE;
                    s_next.strobe = 1'b0;
                end else begin
                    s_next.cnt = s_reg.cnt - 6'h01;
                end
            end
            default: begin
                s_next.acc    = ACC_IDLE;
                s_next.strobe = 1'b0;
            end
        endcase

        // Output flops
        s_next.busy = s_next.acc != ACC_IDLE;
        s_next.pwr  = !s_next.glob[GLB_PDOWN];
    end

    // ==================================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg             <= '0;
            s_reg.glob        <= RST_GLOBAL;
            s_reg.mask        <= RST_MASK;
            s_reg.memt        <= RST_MEMT;
            s_reg.iot         <= RST_IOT;

            s_reg.sync1       <= RST_PINS;
            s_reg.sync2       <= RST_PINS;
            s_reg.sync3       <= RST_PINS;
            s_reg.stable      <= RST_PINS;

            s_reg.rsp.awready <= 1'b1;
            s_reg.rsp.wready  <= 1'b1;
            s_reg.rsp.arready <= 1'b1;
            s_reg.acc         <= ACC_IDLE;
            s_reg.pwr         <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==================================================================
    // Half-cycle strobe retiming
    always_ff @(negedge aclk) begin
        if (!aresetn) begin
            card_output_enable_n <= 1'b1;
            card_write_enable_n  <= 1'b1;
        end else begin
            card_output_enable_n <= !(s_reg.strobe && !s_reg.acc_wr);
            card_write_enable_n  <= !(s_reg.strobe && s_reg.acc_wr);
        end
    end

    // ==================================================================
    // Outputs
    assign s_axi_rsp         = s_reg.rsp;
    assign card_reset        = s_reg.glob[GLB_RESET];
    assign socket_power_en   = s_reg.pwr;
    assign io_access_16      = s_reg.glob[GLB_IO16];
    assign card_is_io        = s_reg.glob[GLB_TYPE];
    assign status_change_irq = s_reg.irq;
    assign access_busy       = s_reg.busy;

endmodule : pcs_socket_ctrl

`default_nettype wire

//--- rtl/pcs_pkg.sv
// Purpose: Shared constants and carrier types of the socket control block
// Assumes: 32-bit AXI4-Lite register access, 8-bit registers in the low lane
// Notes:   Half-cycle strobe delays are produced on the falling clock edge
`default_nettype none

package pcs_pkg;

    // ==================================================================
    // Register offsets
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] OFS_GLOBAL = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_MEMT   = 8'h08;
    localparam logic [7:0] OFS_IOT    = 8'h0c;
    localparam logic [7:0] OFS_CHG    = 8'h10;
    localparam logic [7:0] OFS_ACC    = 8'h14;

    // ==================================================================
    // Field positions
    localparam int GLB_RESET = 5;
    localparam int GLB_SWCD  = 4;
    localparam int GLB_TYPE  = 3;
    localparam int GLB_IO16  = 2;
    localparam int GLB_EXPL  = 1;
    localparam int GLB_PDOWN = 0;
    localparam int MSK_RISC  = 7;
    localparam int MSK_CD    = 6;
    localparam int MSK_IRQ_H = 5;
    localparam int MSK_IRQ_L = 4;
    localparam int MSK_RI    = 3;
    localparam int MSK_RDY   = 2;
    localparam int MSK_BD    = 0;
    localparam int CHG_SWCD  = 7;
    localparam int CHG_CD    = 6;
    localparam int CHG_IRQ   = 5;
    localparam int CHG_STS   = 4;
    localparam int CHG_RI    = 3;
    localparam int CHG_RDY   = 2;
    localparam int TIM_WT_H  = 6;
    localparam int TIM_WT_L  = 4;
    localparam int TIM_AS_H  = 3;
    localparam int TIM_AS_L  = 2;
    localparam int TIM_NG_H  = 1;
    localparam int TIM_NG_L  = 0;
    localparam int ACC_START = 0;
    localparam int ACC_WRITE = 1;
    localparam int ACC_IO    = 2;
    localparam int PIN_IRQ   = 0;
    localparam int PIN_STS   = 1;
    localparam int PIN_RDY   = 2;
    localparam int PIN_CD    = 3;

    // ==================================================================
    // Reset values and codes
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_MASK   = 8'h00;
    localparam logic [7:0] RST_MEMT   = 8'h00;
    localparam logic [7:0] RST_IOT    = 8'h49;
    localparam logic [3:0] RST_PINS   = 4'hb;
    localparam logic [1:0] IRQ_OFF    = 2'h0;
    localparam logic [1:0] IRQ_LEVEL  = 2'h1;
    localparam logic [1:0] IRQ_FALL   = 2'h2;
    localparam logic [1:0] IRQ_RISE   = 2'h3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // ==================================================================
    // Timing counts in bus clocks
    localparam int         CLK_HZ = 10_000_000;
    localparam logic [5:0] WAIT_CLK [8] = '{6'h05, 6'h06, 6'h07, 6'h09,
                                            6'h0b, 6'h0c, 6'h0e, 6'h1c};
    localparam logic [5:0] DLY_FULL [4] = '{6'h00, 6'h01, 6'h03, 6'h05};

    // ==================================================================
    // Bus carriers
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } pcs_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pcs_axi_rsp_t;

endpackage : pcs_pkg

`default_nettype wire

//--- dv/pcs_socket_checker.sv
// Purpose: Port assertions for the socket control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the design top
`default_nettype none

module pcs_socket_checker (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire pcs_pkg::pcs_axi_req_t s_axi_req,
    input wire pcs_pkg::pcs_axi_rsp_t s_axi_rsp,
    input wire logic                  card_reset,
    input wire logic                  socket_power_en,
    input wire logic                  io_access_16,
    input wire logic                  access_busy,
    input wire logic                  card_output_enable_n,
    input wire logic                  card_write_enable_n
);
    timeunit 1ns;
    timeprecision 1ns;
    import pcs_pkg::*;

    // ==================================================================
    // Bus and pin relations
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_answer: assert property (s_axi_req.arvalid && s_axi_rsp.arready
        |=> s_axi_rsp.rvalid && !s_axi_rsp.arready) else $error("read answer late");
    a_read_hold: assert property (s_axi_rsp.rvalid && !s_axi_req.rready
        |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata)) else $error("read data dropped");
    a_write_hold: assert property (s_axi_rsp.bvalid && !s_axi_req.bready
        |=> s_axi_rsp.bvalid && $stable(s_axi_rsp.bresp)) else $error("write resp dropped");
    a_write_answer: assert property (s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid
        && s_axi_rsp.wready |-> ##[1:2] s_axi_rsp.bvalid) else $error("write answer late");
    a_reset_follow: assert property (
        $changed(card_reset) |-> $rose(s_axi_rsp.bvalid)) else $error("card reset moved alone");
    a_power_follow: assert property (
        $changed(socket_power_en) |-> $rose(s_axi_rsp.bvalid)) else $error("power moved alone");
    a_width_follow: assert property (
        $changed(io_access_16) |-> $rose(s_axi_rsp.bvalid)) else $error("io width moved alone");
    a_strobe_busy: assert property (
        $fell(card_output_enable_n) || $fell(card_write_enable_n) |-> access_busy)
        else $error("strobe without busy");
    a_strobe_min: assert property (
        $fell(card_output_enable_n) |-> !card_output_enable_n [*5]) else $error("strobe short");
    a_strobe_max: assert property (
        $fell(card_write_enable_n) |-> ##[1:34] card_write_enable_n) else $error("strobe long");
    a_strobe_excl: assert property (
        card_output_enable_n || card_write_enable_n) else $error("both strobes low");

endmodule : pcs_socket_checker

bind pcs_socket_ctrl pcs_socket_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_req(s_axi_req), .s_axi_rsp(s_axi_rsp), .card_reset(card_reset),
    .socket_power_en(socket_power_en), .io_access_16(io_access_16),
    .access_busy(access_busy), .card_output_enable_n(card_output_enable_n),
    .card_write_enable_n(card_write_enable_n));

`default_nettype wire

//--- dv/pcs_card_model.sv
// Purpose: Behavioural card in the socket
// Assumes: Request pin follows the bench command
// Notes:   Measures strobe low time in bus clocks
`default_nettype none

module pcs_card_model (
    input  wire logic aclk,
    input  wire logic irq_cmd,
    input  wire logic sts_cmd,
    input  wire logic card_output_enable_n,
    input  wire logic card_write_enable_n,
    output logic      card_irq_req_n,
    output logic      status_changed_n,
    output logic      card_ready,
    output logic      card_detect_n,
    output logic [5:0] strobe_len,
    output logic      strobe_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [5:0] cnt = 6'h00;

    assign card_irq_req_n   = irq_cmd;
    assign status_changed_n = sts_cmd;
    assign card_ready       = !sts_cmd;
    assign card_detect_n    = 1'b0;

    // ==================================================================
    // Strobe length in bus clocks
    always @(posedge aclk) begin
        strobe_done <= 1'b0;
        if (!(card_output_enable_n && card_write_enable_n)) begin
            cnt <= cnt + 6'h01;
        end else if (cnt != 6'h00) begin
            strobe_len  <= cnt;
            strobe_done <= 1'b1;
            cnt         <= 6'h00;
        end
    end

endmodule : pcs_card_model

`default_nettype wire

//--- dv/tb_top.sv
// Purpose: Self-checking bench of the socket control block
// Assumes: AXI4-Lite master tasks, card model on the pins
// Notes:   Read results are checked by a queue monitor
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pcs_pkg::*;

    logic         aclk, aresetn, irq_cmd, irq_n, sts_n, rdy, cd_n, sts_cmd;
    logic         card_reset, socket_power_en, io_access_16, card_is_io;
    logic         status_change_irq, access_busy, oe_n, we_n, strobe_done;
    logic [5:0]   strobe_len;
    pcs_axi_req_t req;
    pcs_axi_rsp_t rsp;
    logic [33:0]  exp_q [$];
    logic [7:0]   lvl_a [4] = '{8'h00, 8'h20, 8'h20, 8'h00};
    logic [7:0]   lvl_b [4] = '{8'h00, 8'h20, 8'h00, 8'h20};
    int           err_count = 0;
    int           checked = 0;
    int           seed;

    pcs_socket_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
        .card_irq_req_n(irq_n), .status_changed_n(sts_n), .card_ready(rdy),
        .card_detect_n(cd_n), .card_reset(card_reset), .socket_power_en(socket_power_en),
        .io_access_16(io_access_16), .card_is_io(card_is_io),
        .status_change_irq(status_change_irq), .access_busy(access_busy),
        .card_output_enable_n(oe_n), .card_write_enable_n(we_n));

    pcs_card_model i_card (.aclk(aclk), .irq_cmd(irq_cmd), .sts_cmd(sts_cmd),
        .card_output_enable_n(oe_n),
        .card_write_enable_n(we_n), .card_irq_req_n(irq_n), .status_changed_n(sts_n),
        .card_ready(rdy), .card_detect_n(cd_n), .strobe_len(strobe_len),
        .strobe_done(strobe_done));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // ==================================================================
    // Checking and closing
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic hang;
        err_count++;
        complete_run();
    endtask : hang

    always @(posedge aclk) begin
        if (req.rready && rsp.rvalid) begin
            if (exp_q.size() == 0) check({rsp.rresp, rsp.rdata}, 34'h3ffffffff);
            else check({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        end
    end

    // ==================================================================
    // Register bus master
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h0, d};
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        exp_q.push_back({r, 24'h0, d});
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                req.rready <= 1'b0;
                return;
            end
        end
        hang();
    endtask : rd

    // ==================================================================
    // Scenarios
    initial begin
        int         i;
        int         n;
        logic [7:0] t;
        seed    = 54444;
        req     = '0;
        aresetn = 1'b0;
        irq_cmd = 1'b1;
        sts_cmd = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_GLOBAL, RST_GLOBAL);
        rd(OFS_MASK, RST_MASK);
        rd(OFS_MEMT, RST_MEMT);
        rd(OFS_IOT, RST_IOT);
        rd(8'h40, 8'h00, RESP_SLV);
        wr(OFS_GLOBAL, 8'h2d);
        check({30'h0, card_reset, socket_power_en, io_access_16, card_is_io}, 34'hb);
        rd(OFS_GLOBAL, 8'h2d);
        wr(OFS_GLOBAL, 8'h1c);
        check({30'h0, card_reset, socket_power_en, io_access_16, card_is_io}, 34'h7);
        rd(OFS_CHG, 8'h80);
        rd(OFS_CHG, 8'h00);
        wr(OFS_GLOBAL, 8'h00);
        wr(OFS_MASK, 8'h40);
        wr(OFS_GLOBAL, 8'h10);
        repeat (2) @(posedge aclk);
        check({33'h0, status_change_irq}, 34'h1);
        rd(OFS_CHG, 8'h80);
        wr(OFS_GLOBAL, 8'h12);
        rd(OFS_CHG, 8'h80);
        rd(OFS_CHG, 8'h80);
        wr(OFS_CHG, 8'h80);
        rd(OFS_CHG, 8'h00);
        wr(OFS_MASK, 8'h00);
        wr(OFS_GLOBAL, 8'h10);
        rd(OFS_CHG, 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(OFS_MASK, {2'b00, i[1:0], 4'h0});
            irq_cmd <= 1'b0;
            repeat (8) @(posedge aclk);
            rd(OFS_CHG, lvl_a[i]);
            irq_cmd <= 1'b1;
            repeat (8) @(posedge aclk);
            rd(OFS_CHG, lvl_b[i]);
        end
        wr(OFS_GLOBAL, 8'h08);
        wr(OFS_MASK, 8'h88);
        sts_cmd <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(OFS_CHG, 8'h08);
        wr(OFS_MASK, 8'h85);
        rd(OFS_CHG, 8'h10);
        wr(OFS_GLOBAL, 8'h00);
        sts_cmd <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(OFS_CHG, 8'h14);
        for (i = 0; i < 4; i++) begin
            t = 8'($random(seed));
            if (i == 3) t = RST_IOT;
            else wr(OFS_MEMT, {1'b0, t[6:0]});
            wr(OFS_ACC, {5'h0, i == 3, i[0], 1'b1});
            for (n = 0; n < 100 && !strobe_done; n++) @(posedge aclk);
            if (!strobe_done) hang();
            check({28'h0, strobe_len}, {28'h0, WAIT_CLK[t[6:4]] + DLY_FULL[t[1:0]]});
            rd(OFS_ACC, 8'h00);
        end
        wr(OFS_GLOBAL, 8'h01);
        wr(OFS_ACC, 8'h01);
        repeat (12) @(posedge aclk);
        check({32'h0, socket_power_en, access_busy}, 34'h0);
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
